// ---- verilog/sysreg_pkg.sv ----
package sysreg_pkg;
	// data-memory locations of the system registers
	localparam logic [7:0] ADDR_WIN0 = 8'h00;
	localparam logic [7:0] ADDR_WIN1 = 8'h01;
	localparam logic [7:0] ADDR_PTR0 = 8'h02;
	localparam logic [7:0] ADDR_PTR1 = 8'h03;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_WORK = 8'h05;
	localparam logic [7:0] ADDR_PEND_MAIN = 8'h06;
	localparam logic [7:0] ADDR_EN_MAIN = 8'h07;
	localparam logic [7:0] ADDR_PEND_SECOND = 8'h16;
	localparam logic [7:0] ADDR_EN_SECOND = 8'h17;
	// effective nine-bit address map
	localparam logic [8:0] SYS_TOP = 9'h007;
	localparam logic [8:0] RAM_BASE = 9'h080;
	localparam logic [8:0] RAM_TOP = 9'h17F;
	// status and main-enable field positions
	localparam int ST_BANK1 = 7;
	localparam int ST_BANK0 = 6;
	localparam int ST_SLEEP = 4;
	localparam int ST_WDOG = 3;
	localparam int ST_NIB = 2;
	localparam int ST_CARRY = 1;
	localparam int ST_ZERO = 0;
	localparam int EN_GATE = 7;
	// reset values
	localparam logic [7:0] STATUS_POR = 8'h00;
	localparam logic [7:0] REG_POR = 8'h00;
	localparam logic [4:0] MAIN_POR = 5'h00;
	localparam logic [2:0] SECOND_POR = 3'h0;
	// read pipeline depth in cycles
	localparam int READ_LATENCY = 2;
	typedef enum logic [2:0] {
		ALU_ADD = 3'b000,
		ALU_SUB = 3'b001,
		ALU_AND = 3'b010,
		ALU_OR = 3'b011,
		ALU_XOR = 3'b100,
		ALU_PASS = 3'b101
	} alu_op_e;
endpackage

// ---- verilog/sysreg_ram.sv ----
module sysreg_ram import sysreg_pkg::*; #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input wire logic clk, // core clock
	input wire logic rst_n, // async reset, low
	input wire logic we, // write strobe
	input wire logic re, // read strobe
	input wire logic [AW-1:0] addr, // word address
	input wire logic [DW-1:0] wdata, // write data
	output logic [DW-1:0] rdata_r // registered read data
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= '0;
		end else if (re) begin
			rdata_r <= mem[addr];
		end
	end
endmodule // sysreg_ram

// ---- verilog/sysreg_alu_flags.sv ----
module sysreg_alu_flags import sysreg_pkg::*; (
	input alu_op_e op, // operation
	input wire logic [7:0] a, // first operand
	input wire logic [7:0] b, // second operand
	output logic [7:0] result, // operation result
	output logic zero, // result is zero
	output logic nib_carry, // carry out of bit 3
	output logic carry, // carry out of bit 7
	output logic arith // op touches carry flags
);
	logic [7:0] b_eff;
	logic cin;
	logic [4:0] low_sum;
	logic [8:0] full_sum;

	// subtraction as a + ~b + 1, so carries mean no borrow
	assign arith = (op == ALU_ADD) || (op == ALU_SUB);
	assign b_eff = (op == ALU_SUB) ? ~b : b;
	assign cin = (op == ALU_SUB);
	assign low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
	assign full_sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
	assign nib_carry = low_sum[4];
	assign carry = full_sum[8];

	always_comb begin
		unique case (op)
			ALU_ADD, ALU_SUB: result = full_sum[7:0];
			ALU_AND: result = a & b;
			ALU_OR: result = a | b;
			ALU_XOR: result = a ^ b;
			ALU_PASS: result = a;
			default: result = a;
		endcase
	end

	assign zero = (result == 8'h00);
endmodule // sysreg_alu_flags

// ---- verilog/sysreg_bank.sv ----
module sysreg_bank import sysreg_pkg::*; (
	input wire logic CLK, // core clock
	input wire logic RSTN, // power-on reset, low
	input wire logic WDT_RST, // watchdog reset pulse
	input wire logic SLEEP_EV, // sleep instruction pulse
	input wire logic RD_EN, // data read strobe
	input wire logic WR_EN, // data write strobe
	input wire logic [7:0] ADDR, // direct data address
	input wire logic [7:0] WDATA, // write data
	input wire logic ALU_EN, // instruction updates flags
	input alu_op_e ALU_OP, // alu operation
	input wire logic [7:0] ALU_A, // alu first operand
	input wire logic [7:0] ALU_B, // alu second operand
	input wire logic [7:0] IRQ_EVT, // {ctr,e3,e2,tmr,twi,adc,e1,e0}
	output logic [7:0] RDATA, // read data
	output logic RVALID, // read data valid pulse
	output logic [7:0] ALU_RES, // registered alu result
	output logic IRQ_REQ // interrupt to core
);
	logic [7:0] ptr0_address_r, ptr1_address_r, work_r;
	logic ptr0_bank_bit_r, ptr1_bank_bit_r;
	logic sleep_entered_flag_r, watchdog_expiry_flag_r;
	logic nibble_carry_flag_r, carry_r, zero_r;
	logic master_irq_gate_r;
	logic [4:0] irq_pending_main_r, irq_mask_main_r;
	logic [2:0] irq_pending_second_r, irq_mask_second_r;
	logic [7:0] status_val, en_main_val;
	logic hit_win0, hit_win1, acc;
	logic [8:0] eff;
	logic in_sys, in_ram, rd_ram, wr_ram;
	logic [7:0] ram_addr, ram_q, spec_val;
	logic wr_status, wr_ptr0, wr_ptr1, wr_work, wr_pm, wr_em, wr_ps, wr_es;
	logic [7:0] alu_res;
	logic alu_z, alu_dc, alu_c, alu_arith;
	logic prot_arith, prot_zero;
	logic [4:0] pend_main_nxt;
	logic [2:0] pend_second_nxt;
	logic irq_nxt;
	logic rd_v1_r, sel_ram_r;
	logic [7:0] spec_r;

	// window redirection through the pointers
	assign acc = RD_EN || WR_EN;
	assign hit_win0 = (ADDR == ADDR_WIN0);
	assign hit_win1 = (ADDR == ADDR_WIN1);
	assign eff = hit_win0 ? {ptr0_bank_bit_r, ptr0_address_r} :
		hit_win1 ? {ptr1_bank_bit_r, ptr1_address_r} : {1'b0, ADDR};
	// second interrupt pair sits outside the low system slots
	assign in_sys = (eff <= SYS_TOP) || (eff == {1'b0, ADDR_PEND_SECOND}) ||
		(eff == {1'b0, ADDR_EN_SECOND});
	assign in_ram = (eff >= RAM_BASE) && (eff <= RAM_TOP);
	assign ram_addr = 8'(eff - RAM_BASE);
	assign rd_ram = RD_EN && in_ram;
	assign wr_ram = WR_EN && in_ram;

	// register writes decoded on the effective address
	assign wr_status = WR_EN && (eff == {1'b0, ADDR_STATUS});
	assign wr_ptr0 = WR_EN && (eff == {1'b0, ADDR_PTR0});
	assign wr_ptr1 = WR_EN && (eff == {1'b0, ADDR_PTR1});
	assign wr_work = WR_EN && (eff == {1'b0, ADDR_WORK});
	assign wr_pm = WR_EN && (eff == {1'b0, ADDR_PEND_MAIN});
	assign wr_em = WR_EN && (eff == {1'b0, ADDR_EN_MAIN});
	assign wr_ps = WR_EN && (eff == {1'b0, ADDR_PEND_SECOND});
	assign wr_es = WR_EN && (eff == {1'b0, ADDR_EN_SECOND});

	sysreg_ram #(.AW(8), .DW(8)) u_ram (
		.clk(CLK),
		.rst_n(RSTN),
		.we(wr_ram),
		.re(rd_ram),
		.addr(ram_addr),
		.wdata(WDATA),
		.rdata_r(ram_q)
	);

	sysreg_alu_flags u_alu (
		.op(ALU_OP),
		.a(ALU_A),
		.b(ALU_B),
		.result(alu_res),
		.zero(alu_z),
		.nib_carry(alu_dc),
		.carry(alu_c),
		.arith(alu_arith)
	);

	// flag-updating instruction owns zero, and for add/sub the carry bits, over a status write
	assign prot_arith = ALU_EN && alu_arith;
	assign prot_zero = ALU_EN;

	assign status_val = {ptr1_bank_bit_r, ptr0_bank_bit_r, 1'b0, sleep_entered_flag_r,
		watchdog_expiry_flag_r, nibble_carry_flag_r, carry_r, zero_r};
	assign en_main_val = {master_irq_gate_r, 2'b00, irq_mask_main_r};

	// windows read as zero when a pointer targets a window
	always_comb begin
		spec_val = 8'h00;
		if (eff == {1'b0, ADDR_PTR0}) spec_val = ptr0_address_r;
		if (eff == {1'b0, ADDR_PTR1}) spec_val = ptr1_address_r;
		if (eff == {1'b0, ADDR_STATUS}) spec_val = status_val;
		if (eff == {1'b0, ADDR_WORK}) spec_val = work_r;
		if (eff == {1'b0, ADDR_PEND_MAIN}) spec_val = {3'b000, irq_pending_main_r};
		if (eff == {1'b0, ADDR_EN_MAIN}) spec_val = en_main_val;
		if (eff == {1'b0, ADDR_PEND_SECOND}) spec_val = {5'b00000, irq_pending_second_r};
		if (eff == {1'b0, ADDR_EN_SECOND}) spec_val = {5'b00000, irq_mask_second_r};
	end

	// events win over a clearing write
	assign pend_main_nxt = (wr_pm ? WDATA[4:0] : irq_pending_main_r) | IRQ_EVT[4:0];
	assign pend_second_nxt = (wr_ps ? WDATA[2:0] : irq_pending_second_r) | IRQ_EVT[7:5];
	assign irq_nxt = master_irq_gate_r && (|(irq_pending_main_r & irq_mask_main_r) ||
		|(irq_pending_second_r & irq_mask_second_r));

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ptr0_address_r <= REG_POR;
			ptr1_address_r <= REG_POR;
			work_r <= REG_POR;
		end else begin
			if (wr_ptr0) ptr0_address_r <= WDATA;
			if (wr_ptr1) ptr1_address_r <= WDATA;
			if (wr_work) work_r <= WDATA;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			{ptr1_bank_bit_r, ptr0_bank_bit_r} <= STATUS_POR[ST_BANK1:ST_BANK0];
			sleep_entered_flag_r <= STATUS_POR[ST_SLEEP];
			watchdog_expiry_flag_r <= STATUS_POR[ST_WDOG];
			{nibble_carry_flag_r, carry_r, zero_r} <= STATUS_POR[ST_NIB:ST_ZERO];
		end else begin
			if (wr_status) begin
				ptr1_bank_bit_r <= WDATA[ST_BANK1];
				ptr0_bank_bit_r <= WDATA[ST_BANK0];
			end
			// cause flags only move by hardware events
			if (SLEEP_EV) sleep_entered_flag_r <= 1'b1;
			if (WDT_RST) watchdog_expiry_flag_r <= 1'b1;
			if (prot_arith) begin
				nibble_carry_flag_r <= alu_dc;
				carry_r <= alu_c;
			end else if (wr_status) begin
				nibble_carry_flag_r <= WDATA[ST_NIB];
				carry_r <= WDATA[ST_CARRY];
			end
			if (prot_zero) zero_r <= alu_z;
			else if (wr_status) zero_r <= WDATA[ST_ZERO];
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			master_irq_gate_r <= 1'b0;
			irq_mask_main_r <= MAIN_POR;
			irq_mask_second_r <= SECOND_POR;
			irq_pending_main_r <= MAIN_POR;
			irq_pending_second_r <= SECOND_POR;
			IRQ_REQ <= 1'b0;
		end else begin
			if (wr_em) begin
				master_irq_gate_r <= WDATA[EN_GATE];
				irq_mask_main_r <= WDATA[4:0];
			end
			if (wr_es) irq_mask_second_r <= WDATA[2:0];
			irq_pending_main_r <= pend_main_nxt;
			irq_pending_second_r <= pend_second_nxt;
			IRQ_REQ <= irq_nxt;
		end
	end

	// two-stage read: memory word or captured register value
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rd_v1_r <= 1'b0;
			sel_ram_r <= 1'b0;
			spec_r <= 8'h00;
			RDATA <= 8'h00;
			RVALID <= 1'b0;
			ALU_RES <= 8'h00;
		end else begin
			rd_v1_r <= RD_EN;
			sel_ram_r <= rd_ram;
			spec_r <= (RD_EN && in_sys) ? spec_val : 8'h00;
			RDATA <= rd_v1_r ? (sel_ram_r ? ram_q : spec_r) : 8'h00;
			RVALID <= rd_v1_r;
			if (ALU_EN) ALU_RES <= alu_res;
		end
	end

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RSTN);

	logic [4:0] nib_sum_chk;
	assign nib_sum_chk = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]};
	logic [8:0] add_sum_chk;
	logic sub_nb_chk, sub_nib_chk;
	assign add_sum_chk = {1'b0, ALU_A} + {1'b0, ALU_B};
	assign sub_nb_chk = (ALU_A >= ALU_B);
	assign sub_nib_chk = (ALU_A[3:0] >= ALU_B[3:0]);

	sequence s_win0_read;
		RD_EN && hit_win0;
	endsequence
	sequence s_win1_write;
		WR_EN && hit_win1 && ({ptr1_bank_bit_r, ptr1_address_r} >= RAM_BASE) &&
			({ptr1_bank_bit_r, ptr1_address_r} <= RAM_TOP);
	endsequence
	sequence s_self_point;
		RD_EN && hit_win0 && ({ptr0_bank_bit_r, ptr0_address_r} <= 9'h001);
	endsequence
	sequence s_read_taken;
		RD_EN;
	endsequence
	sequence s_read_answer;
		##2 RVALID;
	endsequence

	a_win0_read_addr: assert property (s_win0_read |-> rd_ram ==
		(({ptr0_bank_bit_r, ptr0_address_r} >= RAM_BASE) &&
		({ptr0_bank_bit_r, ptr0_address_r} <= RAM_TOP)))
		else $error("window 0 read not routed by pointer");
	a_win1_write_ram: assert property (s_win1_write |-> wr_ram &&
		(ram_addr == 8'({ptr1_bank_bit_r, ptr1_address_r} - RAM_BASE)))
		else $error("window 1 write not stored at pointer address");
	a_win_no_store: assert property (s_self_point ##1 1'b1 |=> RVALID && RDATA == 8'h00)
		else $error("window read returned stored value");
	a_status_plain_write: assert property (wr_status && !ALU_EN |=>
		ptr1_bank_bit_r == $past(WDATA[ST_BANK1]) && zero_r == $past(WDATA[ST_ZERO]))
		else $error("status write not stored");
	a_flags_beat_write: assert property (wr_status && ALU_EN && ALU_OP == ALU_ADD |=>
		zero_r == $past(alu_z) && carry_r == $past(alu_c))
		else $error("status write overrode alu flags");
	a_cause_read_only: assert property (wr_status && !WDT_RST && !SLEEP_EV |=>
		$stable(watchdog_expiry_flag_r) && $stable(sleep_entered_flag_r))
		else $error("software changed cause flags");
	a_wdt_sets_flag: assert property (WDT_RST && !WR_EN && !ALU_EN |=>
		watchdog_expiry_flag_r && $stable(ptr0_bank_bit_r) && $stable(zero_r))
		else $error("watchdog reset wrong status effect");
	a_nib_carry_add: assert property (ALU_EN && ALU_OP == ALU_ADD |=>
		nibble_carry_flag_r == $past(nib_sum_chk[4]))
		else $error("nibble carry wrong for add");
	a_pend_sticky: assert property (irq_pending_main_r[0] && !wr_pm |=>
		irq_pending_main_r[0])
		else $error("pending flag lost without clear");
	a_event_beats_clear: assert property (IRQ_EVT[5] && wr_ps |=> irq_pending_second_r[0])
		else $error("event lost under clear");
	a_irq_gated: assert property (!master_irq_gate_r |=> !IRQ_REQ)
		else $error("request with gate off");
	// flags against sums formed apart from the alu
	a_carry_add: assert property (ALU_EN && ALU_OP == ALU_ADD |=>
		carry_r == $past(add_sum_chk[8]))
		else $error("carry wrong for add");
	a_borrow_sub: assert property (ALU_EN && ALU_OP == ALU_SUB |=>
		carry_r == $past(sub_nb_chk) && nibble_carry_flag_r == $past(sub_nib_chk))
		else $error("borrow flags wrong for sub");
	a_zero_result: assert property (ALU_EN |=> zero_r == (ALU_RES == 8'h00))
		else $error("zero flag disagrees with result");
	a_sleep_sets_flag: assert property (SLEEP_EV |=> sleep_entered_flag_r)
		else $error("sleep event not recorded");
	a_page_win0: assert property ((rd_ram || wr_ram) && hit_win0 |->
		ram_addr[7] == ptr0_bank_bit_r)
		else $error("window 0 page bit not applied");
	a_page_win1: assert property ((rd_ram || wr_ram) && hit_win1 |->
		ram_addr[7] == ptr1_bank_bit_r)
		else $error("window 1 page bit not applied");
	a_en_main_write: assert property (wr_em |=> en_main_val == ($past(WDATA) & 8'h9F))
		else $error("main enable write not stored");
	a_en_second_write: assert property (wr_es |=>
		{5'b00000, irq_mask_second_r} == ($past(WDATA) & 8'h07))
		else $error("second enable write not stored");
	a_pend_main_write: assert property (wr_pm && IRQ_EVT == 8'h00 |=>
		{3'b000, irq_pending_main_r} == ($past(WDATA) & 8'h1F))
		else $error("main pending write not stored");
	a_pend_second_write: assert property (wr_ps && IRQ_EVT == 8'h00 |=>
		{5'b00000, irq_pending_second_r} == ($past(WDATA) & 8'h07))
		else $error("second pending write not stored");
	a_event_sets_pend: assert property (IRQ_EVT != 8'h00 |=>
		({irq_pending_second_r, irq_pending_main_r} & $past(IRQ_EVT)) == $past(IRQ_EVT))
		else $error("event did not set its pending flag");
	a_irq_raise: assert property (master_irq_gate_r &&
		((|(irq_pending_main_r & irq_mask_main_r)) || (|(irq_pending_second_r & irq_mask_second_r)))
		|=> IRQ_REQ) else $error("enabled pending source not requested");
	a_irq_no_source: assert property (!(|(irq_pending_main_r & irq_mask_main_r)) &&
		!(|(irq_pending_second_r & irq_mask_second_r)) |=> !IRQ_REQ)
		else $error("request without enabled pending source");
	a_read_answer: assert property (s_read_taken |-> s_read_answer)
		else $error("read answer not two cycles after request");
	a_no_stray_answer: assert property (!RD_EN |-> ##2 !RVALID)
		else $error("read answer without request");
endmodule // sysreg_bank

// ---- tb/core_model.sv ----
module core_model import sysreg_pkg::*; (
	input wire logic clk, // core clock
	output logic wdt_rst, // watchdog pulse
	output logic sleep_ev, // sleep pulse
	output logic rd_en, // read strobe
	output logic wr_en, // write strobe
	output logic [7:0] addr, // data address
	output logic [7:0] wdata, // write data
	output logic alu_en, // flag update strobe
	output alu_op_e alu_op, // alu operation
	output logic [7:0] alu_a, // first operand
	output logic [7:0] alu_b, // second operand
	output logic [7:0] irq_evt // event pulses
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{rd_en, wr_en, alu_en, wdt_rst, sleep_ev} = 5'h00;
		{addr, wdata, alu_a, alu_b, irq_evt} = 40'h00_0000_0000;
		alu_op = ALU_PASS;
	end
	// one cycle per request, then bus released with a changed pattern
	task automatic issue(input logic r, w, e, input logic [7:0] a, d, input alu_op_e op,
		input logic [7:0] x, y, ev, input logic wd, sl);
		@(negedge clk);
		{rd_en, wr_en, alu_en, wdt_rst, sleep_ev} = {r, w, e, wd, sl};
		{addr, wdata, alu_a, alu_b, irq_evt} = {a, d, x, y, ev};
		alu_op = op;
		@(negedge clk);
		{rd_en, wr_en, alu_en, wdt_rst, sleep_ev} = 5'h00;
		{addr, wdata, alu_a, alu_b} = ~{addr, wdata, alu_a, alu_b};
		irq_evt = 8'h00;
	endtask
	task automatic rd(input logic [7:0] a);
		issue(1'b1, 1'b0, 1'b0, a, wdata, ALU_PASS, alu_a, alu_b, 8'h00, 1'b0, 1'b0);
	endtask
	task automatic wr(input logic [7:0] a, d);
		issue(1'b0, 1'b1, 1'b0, a, d, ALU_PASS, alu_a, alu_b, 8'h00, 1'b0, 1'b0);
	endtask
endmodule // core_model

// ---- tb/test_cpu_system_register_bank.sv ----
module test_cpu_system_register_bank import sysreg_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, wdt_rst, sleep_ev, rd_en, wr_en, alu_en, rvalid, irq_req;
	logic [7:0] addr, wdata, alu_a, alu_b, irq_evt, rdata, alu_res, st, d, a, p, m;
	alu_op_e alu_op;
	logic [7:0] exp_q[$];
	logic [7:0] regs[5] = '{ADDR_STATUS, ADDR_PEND_MAIN, ADDR_EN_MAIN, ADDR_PEND_SECOND,
		ADDR_EN_SECOND};
	logic [7:0] msk[5] = '{8'hC7, 8'h1F, 8'h9F, 8'h07, 8'h07};
	logic [31:0] seed = 32'h691e_3f74;
	int mismatches = 0;
	int check_count = 0;
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	core_model core (.clk(clk), .wdt_rst(wdt_rst), .sleep_ev(sleep_ev), .rd_en(rd_en),
		.wr_en(wr_en), .addr(addr), .wdata(wdata), .alu_en(alu_en), .alu_op(alu_op),
		.alu_a(alu_a), .alu_b(alu_b), .irq_evt(irq_evt));
	sysreg_bank dut (.CLK(clk), .RSTN(rstn), .WDT_RST(wdt_rst), .SLEEP_EV(sleep_ev),
		.RD_EN(rd_en), .WR_EN(wr_en), .ADDR(addr), .WDATA(wdata), .ALU_EN(alu_en),
		.ALU_OP(alu_op), .ALU_A(alu_a), .ALU_B(alu_b), .IRQ_EVT(irq_evt), .RDATA(rdata),
		.RVALID(rvalid), .ALU_RES(alu_res), .IRQ_REQ(irq_req));
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
	endfunction
	task automatic chk(input logic [7:0] got, exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// oldest expectation is taken as each read answer appears
	always @(negedge clk) begin
		if (rvalid === 1'b1 && exp_q.size() > 0)
			chk(rdata, exp_q.pop_front());
		else if (rvalid === 1'b1) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, rdata, 8'h00);
		end
	end
	task automatic rd(input logic [7:0] ad, ex);
		exp_q.push_back(ex);
		core.rd(ad);
	endtask
	task automatic wst(input logic [7:0] v);
		st = {v[7:6], 1'b0, st[4:3], v[2:0]};
		core.wr(ADDR_STATUS, v);
	endtask
	task automatic ev(input logic [7:0] v, input logic wd, sl);
		core.issue(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, ALU_PASS, 8'h00, 8'h00, v, wd, sl);
	endtask
	task automatic do_alu(input alu_op_e op, input logic [7:0] x, y, input logic w,
		input logic [7:0] wd);
		logic [8:0] s;
		logic [7:0] ex;
		s = (op == ALU_SUB) ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
		case (op)
			ALU_AND: ex = x & y;
			ALU_OR: ex = x | y;
			ALU_XOR: ex = x ^ y;
			ALU_PASS: ex = x;
			default: ex = s[7:0];
		endcase
		if (w)
			st = {wd[7:6], 1'b0, st[4:3], wd[2:0]};
		st[0] = (ex == 8'h00);
		if (op == ALU_ADD)
			st[2:1] = {({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'h0F, s[8]};
		if (op == ALU_SUB)
			st[2:1] = {x[3:0] >= y[3:0], ~s[8]};
		core.issue(1'b0, w, 1'b1, ADDR_STATUS, wd, op, x, y, 8'h00, 1'b0, 1'b0);
		chk(alu_res, ex);
		rd(ADDR_STATUS, st);
	endtask
	initial begin
		#200000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		rstn = 1'b0;
		st = 8'h00;
		repeat (16) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		foreach (regs[i])
			rd(regs[i], 8'h00);
		foreach (regs[i]) begin
			core.wr(regs[i], 8'hFF);
			rd(regs[i], msk[i]);
			core.wr(regs[i], 8'h00);
			rd(regs[i], 8'h00);
		end
		core.wr(8'h08, 8'hFF);
		rd(8'h08, 8'h00);
		$display("test register map done");
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			d = seed[7:0];
			a = 8'h80 | seed[14:8];
			p = k[0] ? {1'b0, a[6:0]} : a;
			core.wr(a, ~d);
			wst({k[0], k[0], 6'h00});
			core.wr(ADDR_PTR0, p);
			core.wr(ADDR_PTR1, p);
			core.wr(ADDR_WIN0, d);
			rd(ADDR_WIN1, d);
			rd(a, k[0] ? ~d : d);
		end
		wst(8'h07);
		core.wr(ADDR_PTR0, ADDR_STATUS);
		rd(ADDR_WIN0, st);
		core.wr(ADDR_PTR0, ADDR_WIN1);
		rd(ADDR_WIN0, 8'h00);
		$display("test indirect access done");
		for (int k = 0; k < 12; k++) begin
			seed = lfsr(seed);
			do_alu(alu_op_e'(k % 6), seed[7:0], seed[15:8], seed[16], seed[31:24]);
		end
		do_alu(ALU_ADD, 8'hFF, 8'h01, 1'b0, 8'h00);
		do_alu(ALU_SUB, 8'h10, 8'h01, 1'b1, 8'h38);
		do_alu(ALU_SUB, 8'h00, 8'h01, 1'b0, 8'h00);
		do_alu(ALU_ADD, 8'h88, 8'h88, 1'b1, 8'h07);
		$display("test flags done");
		ev(8'h00, 1'b1, 1'b0);
		st[3] = 1'b1;
		rd(ADDR_STATUS, st);
		ev(8'h00, 1'b0, 1'b1);
		st[4] = 1'b1;
		wst(8'h00);
		rd(ADDR_STATUS, st);
		repeat (3) @(negedge clk);
		@(negedge clk) rstn = 1'b0;
		@(negedge clk) rstn = 1'b1;
		st = 8'h00;
		rd(ADDR_STATUS, 8'h00);
		$display("test cause flags done");
		for (int i = 0; i < 8; i++) begin
			m = 8'h01 << i;
			core.wr(ADDR_EN_MAIN, 8'h80 | (i < 5 ? m : 8'h00));
			core.wr(ADDR_EN_SECOND, i < 5 ? 8'h00 : m >> 5);
			ev(m, 1'b0, 1'b0);
			chk({7'h00, irq_req}, 8'h00);
			@(negedge clk);
			chk({7'h00, irq_req}, 8'h01);
			rd(i < 5 ? ADDR_PEND_MAIN : ADDR_PEND_SECOND, i < 5 ? m : m >> 5);
			core.wr(ADDR_EN_MAIN, i < 5 ? m : 8'h00);
			@(negedge clk);
			chk({7'h00, irq_req}, 8'h00);
			core.wr(i < 5 ? ADDR_PEND_MAIN : ADDR_PEND_SECOND, 8'h00);
		end
		core.issue(1'b0, 1'b1, 1'b0, ADDR_PEND_SECOND, 8'h00, ALU_PASS, 8'h00, 8'h00, 8'h20,
			1'b0, 1'b0);
		rd(ADDR_PEND_SECOND, 8'h01);
		core.wr(ADDR_PEND_SECOND, 8'h00);
		$display("test interrupts done");
		repeat (4) @(negedge clk);
		chk(8'(exp_q.size()), 8'h00);
		tally_and_finish;
	end
endmodule // test_cpu_system_register_bank
